/* verilog/clp_detector.sv */
// Added by the designer: the Wishbone slave port and the placing of the registers.
`timescale 1ns/100ps

module clp_detector #(
    parameter int CUR_W = 16,
    parameter int TIM_W = 32,
    parameter int TICK  = clp_pkg::TICK_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire clp_pkg::clp_wb_req_t wb_req_i,
    output logic                      wb_ack_o,
    output logic [31:0]               wb_dat_o,
    input  wire logic                 breaker_open_i,
    input  wire logic [CUR_W-1:0]     current_i,
    input  wire logic                 ext_block_i,
    input  wire logic                 auto_reclose_i,
    output logic                      cold_load_active_o,
    output logic                      low_current_flag_o
);
    import clp_pkg::*;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [31:0]      ctrl_ff, nxt_ctrl;
    logic [CUR_W-1:0] uc_thr_ff, nxt_uc_thr, in_thr_ff, nxt_in_thr;
    logic [TIM_W-1:0] t_off_ff, nxt_t_off, t_set_ff, nxt_t_set, t_max_ff, nxt_t_max;
    logic             ack_ff, nxt_ack;
    logic [31:0]      rdat_ff, nxt_rdat;
    logic             bus_req;
    logic [31:0]      status_w;

    assign bus_req = wb_req_i.cyc && wb_req_i.stb && !ack_ff;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    always_comb begin
        nxt_ctrl   = ctrl_ff;
        nxt_uc_thr = uc_thr_ff;
        nxt_in_thr = in_thr_ff;
        nxt_t_off  = t_off_ff;
        nxt_t_set  = t_set_ff;
        nxt_t_max  = t_max_ff;
        nxt_ack    = bus_req;
        nxt_rdat   = rdat_ff;
        if (bus_req && wb_req_i.we) begin
            case (wb_req_i.adr)
                REG_CTRL:     nxt_ctrl = merge(ctrl_ff, wb_req_i.dat, wb_req_i.sel)
                                         & 32'h0000_000f;
                REG_UC_THR:   nxt_uc_thr = CUR_W'(merge(32'(uc_thr_ff), wb_req_i.dat,
                                                        wb_req_i.sel));
                REG_IN_THR:   nxt_in_thr = CUR_W'(merge(32'(in_thr_ff), wb_req_i.dat,
                                                        wb_req_i.sel));
                REG_T_OFF:    nxt_t_off = TIM_W'(merge(32'(t_off_ff), wb_req_i.dat,
                                                       wb_req_i.sel));
                REG_T_SETTLE: nxt_t_set = TIM_W'(merge(32'(t_set_ff), wb_req_i.dat,
                                                       wb_req_i.sel));
                REG_T_MAXBLK: nxt_t_max = TIM_W'(merge(32'(t_max_ff), wb_req_i.dat,
                                                       wb_req_i.sel));
                default: begin
                end
            endcase
        end
        if (bus_req && !wb_req_i.we) begin
            case (wb_req_i.adr)
                REG_CTRL:     nxt_rdat = ctrl_ff;
                REG_UC_THR:   nxt_rdat = 32'(uc_thr_ff);
                REG_IN_THR:   nxt_rdat = 32'(in_thr_ff);
                REG_T_OFF:    nxt_rdat = 32'(t_off_ff);
                REG_T_SETTLE: nxt_rdat = 32'(t_set_ff);
                REG_T_MAXBLK: nxt_rdat = 32'(t_max_ff);
                REG_STATUS:   nxt_rdat = status_w;
                default:      nxt_rdat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff   <= RST_CTRL;
            uc_thr_ff <= CUR_W'(RST_UC_THR);
            in_thr_ff <= CUR_W'(RST_IN_THR);
            t_off_ff  <= TIM_W'(RST_T_OFF);
            t_set_ff  <= TIM_W'(RST_T_SETTLE);
            t_max_ff  <= TIM_W'(RST_T_MAXBLK);
            ack_ff    <= 1'b0;
            rdat_ff   <= 32'h0000_0000;
        end else begin
            ctrl_ff   <= nxt_ctrl;
            uc_thr_ff <= nxt_uc_thr;
            in_thr_ff <= nxt_in_thr;
            t_off_ff  <= nxt_t_off;
            t_set_ff  <= nxt_t_set;
            t_max_ff  <= nxt_t_max;
            ack_ff    <= nxt_ack;
            rdat_ff   <= nxt_rdat;
        end
    end

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    // ------------------------------------------------------------
    // Millisecond tick divider
    // ------------------------------------------------------------
    logic [31:0] div_ff, nxt_div;
    logic        tick;

    assign tick = (div_ff == 32'(TICK - 1));

    always_comb begin
        nxt_div = tick ? 32'h0000_0000 : div_ff + 32'h0000_0001;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ff <= 32'h0000_0000;
        end else begin
            div_ff <= nxt_div;
        end
    end

    // ------------------------------------------------------------
    // Cold detection
    // ------------------------------------------------------------
    logic [1:0] mode;
    logic       blocked, low_cur, cold, above_in, below_drop;
    logic [CUR_W+3:0] cur_x10, thr_x9;

    assign mode     = ctrl_ff[CTRL_MODE_LSB +: 2];
    // Internal block bit always honoured; external only when selected
    assign blocked  = ctrl_ff[CTRL_BLK_BIT]
                    | (ctrl_ff[CTRL_EXT_BIT] & ext_block_i)
                    | auto_reclose_i;
    assign low_cur  = current_i < uc_thr_ff;
    assign cur_x10  = (CUR_W+4)'(current_i) * (CUR_W+4)'(DROP_DEN);
    assign thr_x9   = (CUR_W+4)'(in_thr_ff) * (CUR_W+4)'(DROP_NUM);
    assign above_in = current_i > in_thr_ff;
    assign below_drop = cur_x10 <= thr_x9;

    always_comb begin
        case (mode)
            MODE_BRK:     cold = breaker_open_i;
            MODE_UC:      cold = low_cur;
            MODE_BRK_AND: cold = breaker_open_i & low_cur;
            MODE_BRK_OR:  cold = breaker_open_i | low_cur;
            default:      cold = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Sequencer with load-off, settle and max-block timers
    // ------------------------------------------------------------
    clp_state_t       st_ff, nxt_st;
    logic [TIM_W-1:0] tmr_ff, nxt_tmr, max_ff, nxt_max;
    logic             act_ff, nxt_act, lowf_ff;

    always_comb begin
        nxt_st  = st_ff;
        nxt_tmr = tmr_ff;
        nxt_max = max_ff;
        nxt_act = act_ff;
        if (blocked) begin
            nxt_st  = ST_WARM;
            nxt_tmr = '0;
            nxt_max = '0;
            nxt_act = 1'b0;
        end else begin
            if (tick && st_ff != ST_WARM) begin
                nxt_tmr = tmr_ff + TIM_W'(1);
            end
            // Max-block runs beside inrush and settle phases
            if (tick && (st_ff == ST_INRUSH || st_ff == ST_SETTLE)) begin
                nxt_max = max_ff + TIM_W'(1);
            end
            case (st_ff)
                ST_WARM: begin
                    if (cold) begin
                        nxt_st  = ST_LOADOF;
                        nxt_tmr = '0;
                    end
                end
                ST_LOADOF: begin
                    if (!cold) begin
                        nxt_st = ST_WARM;
                    end else if (tmr_ff >= t_off_ff) begin
                        nxt_st  = ST_COLD;
                        nxt_act = 1'b1;
                    end
                end
                ST_COLD: begin
                    if (!cold) begin
                        nxt_st  = ST_INRUSH;
                        nxt_tmr = '0;
                        nxt_max = '0;
                    end
                end
                ST_INRUSH: begin
                    // Inrush may never appear; drop-out check alone moves on
                    if (cold) begin
                        nxt_st = ST_COLD;
                    end else if (below_drop && !above_in) begin
                        nxt_st  = ST_SETTLE;
                        nxt_tmr = '0;
                    end
                end
                ST_SETTLE: begin
                    if (cold) begin
                        nxt_st = ST_COLD;
                    end else if (!below_drop) begin
                        nxt_st = ST_INRUSH;
                    end else if (tmr_ff >= t_set_ff) begin
                        nxt_st  = ST_WARM;
                        nxt_act = 1'b0;
                        nxt_max = '0;
                    end
                end
                default: begin
                    nxt_st = ST_WARM;
                end
            endcase
            if ((st_ff == ST_INRUSH || st_ff == ST_SETTLE) && !cold
                && max_ff >= t_max_ff) begin
                nxt_st  = ST_WARM;
                nxt_act = 1'b0;
                nxt_max = '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff   <= ST_WARM;
            tmr_ff  <= '0;
            max_ff  <= '0;
            act_ff  <= 1'b0;
            lowf_ff <= 1'b0;
        end else begin
            st_ff   <= nxt_st;
            tmr_ff  <= nxt_tmr;
            max_ff  <= nxt_max;
            act_ff  <= nxt_act;
            lowf_ff <= low_cur;
        end
    end

    // Indication only: no trip output exists
    assign cold_load_active_o = act_ff;
    assign low_current_flag_o = lowf_ff;
    assign status_w = {24'h00_0000, 1'b0, st_ff, lowf_ff, act_ff};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    blocked_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
        blocked |=> !cold_load_active_o && max_ff == '0)
        else $error("output not cleared when blocked");
    reclose_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
        auto_reclose_i |=> st_ff == ST_WARM)
        else $error("auto reclose did not block");
    loadoff_rise_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(cold_load_active_o) |-> $past(st_ff) == ST_LOADOF && $past(tmr_ff) >= t_off_ff)
        else $error("active rose without load-off expiry");
    start_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff == ST_WARM && cold && !blocked |=> st_ff == ST_LOADOF && tmr_ff == '0)
        else $error("load-off timer not started");
    inrush_go_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff == ST_COLD && !cold && !blocked |=> st_ff == ST_INRUSH && max_ff == '0)
        else $error("inrush detector not started");
    drop_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff == ST_INRUSH && !blocked && !cold && !below_drop |=> st_ff != ST_SETTLE)
        else $error("settle entered above drop-out");
    fall_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(cold_load_active_o) |-> $past(blocked) || $past(max_ff) >= t_max_ff
            || ($past(st_ff) == ST_SETTLE && $past(tmr_ff) >= t_set_ff))
        else $error("active fell without cause");
    max_stop_a: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff == ST_INRUSH && !blocked && !cold && max_ff >= t_max_ff |=> !cold_load_active_o)
        else $error("max-block expiry ignored");
    mode_and_a: assert property (@(posedge clk_i) disable iff (rst_i)
        mode == MODE_BRK_AND && st_ff == ST_WARM && !(breaker_open_i && low_cur)
        |=> st_ff == ST_WARM)
        else $error("AND mode started without both");

endmodule : clp_detector

/* include/clp_pkg.sv */
package clp_pkg;

    // ------------------------------------------------------------
    // Detection modes
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_BRK     = 2'h0;
    localparam logic [1:0] MODE_UC      = 2'h1;
    localparam logic [1:0] MODE_BRK_AND = 2'h2;
    localparam logic [1:0] MODE_BRK_OR  = 2'h3;

    // ------------------------------------------------------------
    // Register map (word addresses on byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_UC_THR   = 8'h04;
    localparam logic [7:0] REG_IN_THR   = 8'h08;
    localparam logic [7:0] REG_T_OFF    = 8'h0c;
    localparam logic [7:0] REG_T_SETTLE = 8'h10;
    localparam logic [7:0] REG_T_MAXBLK = 8'h14;
    localparam logic [7:0] REG_STATUS   = 8'h18;

    // CTRL fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_BLK_BIT  = 2;
    localparam int CTRL_EXT_BIT  = 3;

    // Reset values
    localparam logic [31:0] RST_CTRL     = 32'h0000_0008;
    localparam logic [15:0] RST_UC_THR   = 16'h0010;
    localparam logic [15:0] RST_IN_THR   = 16'h0200;
    localparam logic [31:0] RST_T_OFF    = 32'h0000_0064;
    localparam logic [31:0] RST_T_SETTLE = 32'h0000_0064;
    localparam logic [31:0] RST_T_MAXBLK = 32'h0000_03e8;

    // ------------------------------------------------------------
    // Timing: timers count in milliseconds at 40 MHz
    // ------------------------------------------------------------
    localparam int CLK_HZ      = 40000000;
    localparam int TICK_MS     = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

    // Drop-out ratio 90 percent as 9/10
    localparam int DROP_NUM = 9;
    localparam int DROP_DEN = 10;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } clp_wb_req_t;

    typedef enum logic [4:0] {
        ST_WARM   = 5'h01,
        ST_LOADOF = 5'h02,
        ST_COLD   = 5'h04,
        ST_INRUSH = 5'h08,
        ST_SETTLE = 5'h10
    } clp_state_t;

endpackage : clp_pkg

/* testbench/clp_feeder_model.sv */
`timescale 1ns/100ps

// ----------------------------------------
// Feeder: breaker contacts and phase CTs
// ----------------------------------------
module clp_feeder_model (
    input  wire logic        clk_i,
    input  wire logic        open_cmd_i,
    input  wire logic        slow_i,
    input  wire logic [15:0] load_i,
    output logic             breaker_open_o,
    output logic [15:0]      current_o
);
    int cnt;

    initial begin
        breaker_open_o = 1'b0;
        cnt = 0;
    end

    // Contacts follow the command only after the operating time
    always @(posedge clk_i) begin
        if (open_cmd_i != breaker_open_o) begin
            cnt <= cnt + 1;
            if (cnt >= (slow_i ? 12 : 1)) begin
                breaker_open_o <= open_cmd_i;
                cnt <= 0;
            end
        end else begin
            cnt <= 0;
        end
    end

    // CTs sit behind this breaker, so an open breaker reads no current
    assign current_o = breaker_open_o ? 16'h0000 : load_i;
endmodule : clp_feeder_model

/* testbench/clp_detector_tb_top.sv */
`timescale 1ns/100ps

module clp_detector_tb_top;
    import clp_pkg::*;

`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        err_count++; \
        $display("[FAIL] %0t ns got %h expected %h", $time, got, exp); \
    end \
end

    typedef struct packed {logic p; logic [31:0] m; logic [31:0] d;} clp_exp_t;
    localparam int TK = 4;

    logic        clk_i, rst_i, open_cmd, slow, ext_blk, recl, brk_open, wb_ack, act, lowf;
    logic [15:0] load, cur;
    logic [31:0] wb_dat;
    clp_wb_req_t wb_req;
    int          err_count, tests_run, seed;
    clp_exp_t    exp_q[$];
    clp_exp_t    e;

    clp_detector #(.TICK(TK)) clp_detector_inst (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req), .wb_ack_o(wb_ack),
        .wb_dat_o(wb_dat), .breaker_open_i(brk_open), .current_i(cur),
        .ext_block_i(ext_blk), .auto_reclose_i(recl), .cold_load_active_o(act),
        .low_current_flag_o(lowf));

    clp_feeder_model clp_feeder_model_inst (
        .clk_i(clk_i), .open_cmd_i(open_cmd), .slow_i(slow), .load_i(load),
        .breaker_open_o(brk_open), .current_o(cur));

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // Bus cycles and checks
    // ----------------------------------------
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                      input logic [31:0] m, input logic p);
        exp_q.push_back('{p: p, m: m, d: d});
        @(posedge clk_i);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: d};
        @(posedge clk_i);
        while (wb_ack !== 1'b1) @(posedge clk_i);
        wb_req <= '0;
    endtask : wb

    task automatic rd(input logic [7:0] adr, input logic [31:0] d);
        wb(1'b0, adr, d, 32'hffff_ffff, 1'b0);
    endtask : rd

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        wb(1'b1, adr, d, 32'h0, 1'b0);
    endtask : wr

    // Status bits and both output pins checked together
    task automatic st(input logic low, input logic a);
        wb(1'b0, REG_STATUS, {30'h0, low, a}, 32'h3, 1'b1);
    endtask : st

    task automatic ticks(input int n);
        repeat (n * TK) @(posedge clk_i);
    endtask : ticks

    // Oldest note is matched against each acknowledged cycle
    always @(posedge clk_i) begin
        if (wb_ack === 1'b1 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            if (e.m != 32'h0) begin
                `CHK(wb_dat & e.m, e.d & e.m)
            end
            if (e.p) begin
                `CHK({lowf, act}, e.d[1:0])
            end
        end
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_count++;
        $display("[FAIL] %0t ns watchdog expired", $time);
        end_of_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h0289b415;
        err_count = 0;
        tests_run = 0;
        rst_i = 1'b1;
        wb_req = '0;
        open_cmd = 1'b0;
        slow = 1'b0;
        load = 16'h0080;
        ext_blk = 1'b0;
        recl = 1'b0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(REG_CTRL, RST_CTRL);
        rd(REG_UC_THR, {16'h0, RST_UC_THR});
        rd(REG_IN_THR, {16'h0, RST_IN_THR});
        rd(REG_T_OFF, RST_T_OFF);
        rd(REG_T_SETTLE, RST_T_SETTLE);
        rd(REG_T_MAXBLK, RST_T_MAXBLK);
        wr(8'h1c, 32'hffff_ffff);
        rd(8'h1c, 32'h0);
        // Thresholds keep only their low half; control keeps four bits
        wr(REG_UC_THR, 32'hffff_abcd);
        rd(REG_UC_THR, 32'h0000_abcd);
        wr(REG_UC_THR, {16'h0, RST_UC_THR});
        wr(REG_IN_THR, 32'h0000_0155);
        rd(REG_IN_THR, 32'h0000_0155);
        wr(REG_IN_THR, {16'h0, RST_IN_THR});
        wr(REG_CTRL, 32'hffff_ffff);
        rd(REG_CTRL, 32'h0000_000f);
        wr(REG_CTRL, RST_CTRL);
        wr(REG_STATUS, 32'hffff_ffff);
        st(1'b0, 1'b0);
        wr(REG_T_OFF, 32'h4);
        wr(REG_T_SETTLE, 32'h3);
        wr(REG_T_MAXBLK, 32'h1e);
        rd(REG_T_MAXBLK, 32'h1e);
        $display("Test registers done");
        open_cmd <= 1'b1;
        ticks(2);
        st(1'b1, 1'b0);
        ticks(6);
        st(1'b1, 1'b1);
        load <= 16'h0300;
        open_cmd <= 1'b0;
        ticks(8);
        st(1'b0, 1'b1);
        load <= 16'h01cd;
        ticks(8);
        st(1'b0, 1'b1);
        load <= 16'h01cc;
        ticks(6);
        st(1'b0, 1'b0);
        $display("Test inrush and settle done");
        slow <= 1'b1;
        open_cmd <= 1'b1;
        ticks(10);
        st(1'b1, 1'b1);
        load <= 16'h0300;
        open_cmd <= 1'b0;
        ticks(25);
        st(1'b0, 1'b1);
        ticks(12);
        st(1'b0, 1'b0);
        slow <= 1'b0;
        $display("Test max block done");
        // Breaker stays closed, so only the undercurrent leg can see cold
        for (int m = 0; m < 4; m++) begin
            wr(REG_CTRL, {28'h0, 2'b10, m[1:0]});
            load <= 16'h0000;
            ticks(10);
            st(1'b1, m == 1 || m == 3);
            load <= 16'h0020 + 16'($random(seed) & 32'hff);
            ticks(10);
            st(1'b0, 1'b0);
        end
        $display("Test modes done");
        wr(REG_CTRL, 32'h0000_000a);
        open_cmd <= 1'b1;
        ticks(10);
        st(1'b1, 1'b1);
        ext_blk <= 1'b1;
        ticks(1);
        st(1'b1, 1'b0);
        ext_blk <= 1'b0;
        ticks(2);
        st(1'b1, 1'b0);
        ticks(6);
        st(1'b1, 1'b1);
        wr(REG_CTRL, 32'h0000_0002);
        ext_blk <= 1'b1;
        ticks(1);
        st(1'b1, 1'b1);
        ext_blk <= 1'b0;
        wr(REG_CTRL, 32'h0000_0006);
        st(1'b1, 1'b0);
        wr(REG_CTRL, 32'h0000_000a);
        ticks(8);
        st(1'b1, 1'b1);
        recl <= 1'b1;
        ticks(1);
        st(1'b1, 1'b0);
        recl <= 1'b0;
        ticks(8);
        st(1'b1, 1'b1);
        open_cmd <= 1'b0;
        $display("Test blocking done");
        ticks(2);
        end_of_test();
    end
endmodule : clp_detector_tb_top
